// ==== pif_params.svh ====
// Purpose: Register offsets, field positions, reset values and masks for the peripheral interrupt flag block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Definitions only.
`ifndef PIF_PARAMS_SVH
`define PIF_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define PIF_OFF_FLAGS_ONE 12'h000
`define PIF_OFF_FLAGS_TWO 12'h004
`define PIF_OFF_FLAGS_THREE 12'h008
`define PIF_OFF_ENABLES_ONE 12'h00C
`define PIF_OFF_ENABLES_TWO 12'h010
`define PIF_OFF_ENABLES_THREE 12'h014
`define PIF_OFF_PRIORITY_ONE 12'h018
`define PIF_OFF_PRIORITY_TWO 12'h01C
`define PIF_OFF_PRIORITY_THREE 12'h020
`define PIF_OFF_CONTROL 12'h024
`define PIF_OFF_STATUS 12'h028
// ==========================================================
// Implemented-bit masks
`define PIF_MASK_ONE 8'hFF
`define PIF_MASK_TWO 8'h5F
`define PIF_MASK_THREE 8'h3F
`define PIF_MASK_THREE_SW 8'h0F
// ==========================================================
// Reset values
`define PIF_RST_ZERO 8'h00
`define PIF_RST_PRIO_ONE 8'hFF
`define PIF_RST_PRIO_TWO 8'h5F
`define PIF_RST_PRIO_THREE 8'h3F
// ==========================================================
// Field positions
`define PIF_BIT_T1 0
`define PIF_BIT_T2 1
`define PIF_BIT_PAR 7
`define PIF_BIT_ADC 6
`define PIF_BIT_SSP 3
`define PIF_BIT_CC1 2
`define PIF_BIT_SER1_TX 4
`define PIF_BIT_SER1_RX 5
`define PIF_BIT_CC2 0
`define PIF_BIT_T3 1
`define PIF_BIT_LV 2
`define PIF_BIT_BCL 3
`define PIF_BIT_NVM 4
`define PIF_BIT_CMP 6
`define PIF_BIT_T4 3
`define PIF_BIT_SER2_TX 4
`define PIF_BIT_SER2_RX 5
`define PIF_CTRL_GLOBAL 0
`define PIF_CTRL_PRIO 1
`define PIF_CTRL_MCU 2
`endif

// ==== pif_pkg.sv ====
// Purpose: Types shared by the peripheral interrupt flag block.
// Assumes: Nothing beyond the header.
// Notes: Constants live in pif_params.svh.
package pif_pkg;
	typedef logic [7:0] pif_reg_t;
	typedef logic [2:0] pif_cc_t;
endpackage

// ==== pif_core.sv ====
// Purpose: Peripheral interrupt flags, enables and request gating behind an APB slave.
// Assumes: Event inputs are one-cycle pulses on sys_clk; level inputs other than the comparator and low-voltage pins come from synchronous logic.
// Notes: Write-one-ignored semantics are not used: flags clear when software writes a zero.
// ==========================================================
`timescale 1ns/100ps
`include "pif_params.svh"

module pif_core (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer_one_overflow,
	input wire logic timer_two_match,
	input wire logic timer_three_overflow,
	input wire logic timer_four_match,
	input wire logic parallel_port_event,
	input wire logic adc_done_event,
	input wire logic sync_serial_event,
	input wire logic capcomp_one_event,
	input wire logic capcomp_two_event,
	input wire pif_pkg::pif_cc_t capcomp_three_to_five_events,
	input wire logic capcomp_one_pwm,
	input wire logic capcomp_two_pwm,
	input wire pif_pkg::pif_cc_t capcomp_three_to_five_pwm,
	input wire logic comparator_change,
	input wire logic nvm_write_done,
	input wire logic bus_collision,
	input wire logic low_voltage_trip,
	input wire logic serial_one_rx_full,
	input wire logic serial_one_tx_empty,
	input wire logic serial_two_rx_full,
	input wire logic serial_two_tx_empty,
	output logic irq_high_r,
	output logic irq_low_r
);
	import pif_pkg::*;

	// ==========================================================
	// Bus decode
	logic wr_en, rd_en;
	pif_reg_t wbyte;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign wbyte = pwdata[7:0];

	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a == off);
	endfunction

	pif_reg_t flags_one_r, flags_two_r, flags_three_r;
	pif_reg_t en_one_r, en_two_r, en_three_r;
	pif_reg_t prio_one_r, prio_two_r, prio_three_r;
	logic [2:0] control_r;
	logic ser1_rx_r, ser1_tx_r, ser2_rx_r, ser2_tx_r;
	logic addr_ok;

	// ==========================================================
	// Synchronise asynchronous pin-level sources.
	logic [1:0] cmp_sync_r, lv_sync_r;
	logic cmp_prev_r, lv_prev_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_sync_r <= 2'h0;
			lv_sync_r <= 2'h0;
			cmp_prev_r <= 1'b0;
			lv_prev_r <= 1'b0;
		end else begin
			cmp_sync_r <= {cmp_sync_r[0], comparator_change};
			lv_sync_r <= {lv_sync_r[0], low_voltage_trip};
			cmp_prev_r <= cmp_sync_r[1];
			lv_prev_r <= lv_sync_r[1];
		end
	end

	// ==========================================================
	// Event vectors; PWM-mode units are silenced.
	pif_reg_t set_one, set_two, set_three;
	always_comb begin
		set_one = 8'h00;
		set_one[`PIF_BIT_PAR] = parallel_port_event;
		set_one[`PIF_BIT_ADC] = adc_done_event;
		set_one[`PIF_BIT_SSP] = sync_serial_event;
		set_one[`PIF_BIT_CC1] = capcomp_one_event & ~capcomp_one_pwm;
		set_one[`PIF_BIT_T2] = timer_two_match;
		set_one[`PIF_BIT_T1] = timer_one_overflow;
		set_two = 8'h00;
		set_two[`PIF_BIT_CMP] = cmp_sync_r[1] ^ cmp_prev_r;
		set_two[`PIF_BIT_NVM] = nvm_write_done;
		set_two[`PIF_BIT_BCL] = bus_collision;
		set_two[`PIF_BIT_LV] = lv_sync_r[1] & ~lv_prev_r;
		set_two[`PIF_BIT_T3] = timer_three_overflow;
		set_two[`PIF_BIT_CC2] = capcomp_two_event & ~capcomp_two_pwm;
		set_three = 8'h00;
		set_three[`PIF_BIT_T4] = timer_four_match;
		set_three[2:0] = capcomp_three_to_five_events & ~capcomp_three_to_five_pwm;
	end

	// ==========================================================
	// Sticky flags: an event in the clearing cycle wins over the write.
	// set ignores enables
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_one_r <= `PIF_RST_ZERO;
			flags_two_r <= `PIF_RST_ZERO;
			flags_three_r <= `PIF_RST_ZERO;
		end else begin
			if (wr_en && hit(paddr, `PIF_OFF_FLAGS_ONE)) begin
				flags_one_r <= (wbyte & `PIF_MASK_ONE) | set_one;
			end else begin
				flags_one_r <= flags_one_r | set_one;
			end
			if (wr_en && hit(paddr, `PIF_OFF_FLAGS_TWO)) begin
				flags_two_r <= (wbyte & `PIF_MASK_TWO) | set_two;
			end else begin
				flags_two_r <= flags_two_r | set_two;
			end
			if (wr_en && hit(paddr, `PIF_OFF_FLAGS_THREE)) begin
				flags_three_r <= (wbyte & `PIF_MASK_THREE_SW) | set_three;
			end else begin
				flags_three_r <= (flags_three_r & `PIF_MASK_THREE_SW) | set_three;
			end
		end
	end

	// ==========================================================
	// Buffer-state mirrors, owned by the serial ports; read-only here.
	// receive full mirror
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser1_rx_r <= 1'b0;
			ser1_tx_r <= 1'b0;
			ser2_rx_r <= 1'b0;
			ser2_tx_r <= 1'b0;
		end else begin
			ser1_rx_r <= serial_one_rx_full;
			ser1_tx_r <= serial_one_tx_empty;
			ser2_rx_r <= serial_two_rx_full;
			ser2_tx_r <= serial_two_tx_empty;
		end
	end

	// ==========================================================
	// Enable, priority and control registers.
	// enable one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_one_r <= `PIF_RST_ZERO;
			en_two_r <= `PIF_RST_ZERO;
			en_three_r <= `PIF_RST_ZERO;
			prio_one_r <= `PIF_RST_PRIO_ONE;
			prio_two_r <= `PIF_RST_PRIO_TWO;
			prio_three_r <= `PIF_RST_PRIO_THREE;
			control_r <= 3'h0;
		end else if (wr_en) begin
			if (hit(paddr, `PIF_OFF_ENABLES_ONE)) begin
				en_one_r <= wbyte & `PIF_MASK_ONE;
			end else if (hit(paddr, `PIF_OFF_ENABLES_TWO)) begin
				en_two_r <= wbyte & `PIF_MASK_TWO;
			end else if (hit(paddr, `PIF_OFF_ENABLES_THREE)) begin
				en_three_r <= wbyte & `PIF_MASK_THREE;
			end else if (hit(paddr, `PIF_OFF_PRIORITY_ONE)) begin
				prio_one_r <= wbyte & `PIF_MASK_ONE;
			end else if (hit(paddr, `PIF_OFF_PRIORITY_TWO)) begin
				prio_two_r <= wbyte & `PIF_MASK_TWO;
			end else if (hit(paddr, `PIF_OFF_PRIORITY_THREE)) begin
				prio_three_r <= wbyte & `PIF_MASK_THREE;
			end else if (hit(paddr, `PIF_OFF_CONTROL)) begin
				control_r <= wbyte[2:0];
			end
		end
	end

	// ==========================================================
	// Request gating.
	pif_reg_t view_one, view_three, act_one, act_two, act_three;
	logic pend_hi, pend_lo, prio_on, glob_on;
	always_comb begin
		view_one = flags_one_r;
		view_one[`PIF_BIT_SER1_RX] = ser1_rx_r;
		view_one[`PIF_BIT_SER1_TX] = ser1_tx_r;
		view_three = flags_three_r;
		view_three[`PIF_BIT_SER2_RX] = ser2_rx_r;
		view_three[`PIF_BIT_SER2_TX] = ser2_tx_r;
		act_one = view_one & en_one_r;
		// parallel port only in microcontroller mode
		act_one[`PIF_BIT_PAR] = act_one[`PIF_BIT_PAR] & control_r[`PIF_CTRL_MCU];
		act_two = flags_two_r & en_two_r;
		act_three = view_three & en_three_r;
	end
	assign prio_on = control_r[`PIF_CTRL_PRIO];
	assign glob_on = control_r[`PIF_CTRL_GLOBAL];
	// priority bits matter only in priority mode
	assign pend_hi = prio_on & (|(act_one & prio_one_r) | |(act_two & prio_two_r) | |(act_three & prio_three_r));
	assign pend_lo = |(act_one & ~prio_one_r) | |(act_two & ~prio_two_r) | |(act_three & ~prio_three_r);

	// global enable gates in single mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_high_r <= 1'b0;
			irq_low_r <= 1'b0;
		end else if (prio_on) begin
			irq_high_r <= pend_hi;
			irq_low_r <= pend_lo & glob_on;
		end else begin
			irq_high_r <= glob_on & (|act_one | |act_two | |act_three);
			irq_low_r <= 1'b0;
		end
	end

	// ==========================================================
	// Read mux, registered so prdata comes from a flip-flop; reads are answered
	// from the value captured in the setup cycle, so data is ready at access.
	always_comb begin
		addr_ok = 1'b1;
		if (hit(paddr, `PIF_OFF_FLAGS_ONE) || hit(paddr, `PIF_OFF_FLAGS_TWO)) begin
		end else if (hit(paddr, `PIF_OFF_FLAGS_THREE) || hit(paddr, `PIF_OFF_ENABLES_ONE)) begin
		end else if (hit(paddr, `PIF_OFF_ENABLES_TWO) || hit(paddr, `PIF_OFF_ENABLES_THREE)) begin
		end else if (hit(paddr, `PIF_OFF_PRIORITY_ONE) || hit(paddr, `PIF_OFF_PRIORITY_TWO)) begin
		end else if (hit(paddr, `PIF_OFF_PRIORITY_THREE) || hit(paddr, `PIF_OFF_CONTROL)) begin
		end else if (hit(paddr, `PIF_OFF_STATUS)) begin
		end else begin
			addr_ok = 1'b0;
		end
	end
	// Response flags come from flip-flops, loaded at the setup edge so they
	// stand through the access cycle; pready never drops, so no wait states.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			pslverr <= psel & ~penable & ~addr_ok;
		end
	end

	pif_reg_t rd_byte;
	always_comb begin
		if (hit(paddr, `PIF_OFF_FLAGS_ONE)) begin
			rd_byte = view_one;
		end else if (hit(paddr, `PIF_OFF_FLAGS_TWO)) begin
			rd_byte = flags_two_r;
		end else if (hit(paddr, `PIF_OFF_FLAGS_THREE)) begin
			rd_byte = view_three;
		end else if (hit(paddr, `PIF_OFF_ENABLES_ONE)) begin
			rd_byte = en_one_r;
		end else if (hit(paddr, `PIF_OFF_ENABLES_TWO)) begin
			rd_byte = en_two_r;
		end else if (hit(paddr, `PIF_OFF_ENABLES_THREE)) begin
			rd_byte = en_three_r;
		end else if (hit(paddr, `PIF_OFF_PRIORITY_ONE)) begin
			rd_byte = prio_one_r;
		end else if (hit(paddr, `PIF_OFF_PRIORITY_TWO)) begin
			rd_byte = prio_two_r;
		end else if (hit(paddr, `PIF_OFF_PRIORITY_THREE)) begin
			rd_byte = prio_three_r;
		end else if (hit(paddr, `PIF_OFF_CONTROL)) begin
			rd_byte = {5'h00, control_r};
		end else if (hit(paddr, `PIF_OFF_STATUS)) begin
			rd_byte = {6'h00, irq_low_r, irq_high_r};
		end else begin
			rd_byte = 8'h00;
		end
	end
	// Sampled on the setup cycle; the master holds paddr through access.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end

	// ==========================================================
	// Checks.
	// timer one sticky
	property p_t1_sticky;
		@(posedge sys_clk) disable iff (!rst_n)
		timer_one_overflow |=> flags_one_r[`PIF_BIT_T1];
	endproperty
	a_t1_sticky: assert property (p_t1_sticky)
		else $error("timer one flag not set");
	property p_t2_set;
		@(posedge sys_clk) disable iff (!rst_n)
		timer_two_match |=> flags_one_r[`PIF_BIT_T2];
	endproperty
	a_t2_set: assert property (p_t2_set)
		else $error("timer two flag not set");
	property p_pwm_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		capcomp_two_pwm && !flags_two_r[`PIF_BIT_CC2] && !(wr_en && hit(paddr, `PIF_OFF_FLAGS_TWO))
			|=> !flags_two_r[`PIF_BIT_CC2];
	endproperty
	a_pwm_quiet: assert property (p_pwm_quiet)
		else $error("pwm unit raised flag");
	property p_nvm;
		@(posedge sys_clk) disable iff (!rst_n)
		nvm_write_done |=> flags_two_r[`PIF_BIT_NVM];
	endproperty
	a_nvm: assert property (p_nvm)
		else $error("write done flag missing");
	property p_unimpl;
		@(posedge sys_clk) disable iff (!rst_n)
		flags_two_r[7] == 1'b0 && flags_two_r[5] == 1'b0 && en_three_r[7:6] == 2'h0;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("unimplemented bit set");
	property p_rd_unimpl;
		@(posedge sys_clk) disable iff (!rst_n)
		rd_en && hit(paddr, `PIF_OFF_FLAGS_TWO) |-> prdata[31:8] == 24'h00_0000 && prdata[7] == 1'b0 && prdata[5] == 1'b0;
	endproperty
	a_rd_unimpl: assert property (p_rd_unimpl)
		else $error("unimplemented bit read as one");
	property p_rx2;
		@(posedge sys_clk) disable iff (!rst_n)
		view_three[`PIF_BIT_SER2_RX] == $past(serial_two_rx_full);
	endproperty
	a_rx2: assert property (p_rx2)
		else $error("rx mirror wrong");
	property p_gate;
		@(posedge sys_clk) disable iff (!rst_n)
		!prio_on && !glob_on |=> !irq_high_r && !irq_low_r;
	endproperty
	a_gate: assert property (p_gate)
		else $error("request without global enable");
	property p_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		flags_two_r[`PIF_BIT_T3] && !wr_en |=> flags_two_r[`PIF_BIT_T3];
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag lost without clear");
	c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq_high_r));
	c_low: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq_low_r));
	c_race: cover property (@(posedge sys_clk) disable iff (!rst_n)
		timer_one_overflow && wr_en && hit(paddr, `PIF_OFF_FLAGS_ONE));
endmodule

// ==== pif_periph_model.sv ====
// Purpose: Behavioural model of the peripherals that feed the interrupt flag block.
// Assumes: The bench names one source per command; all outputs change just after sys_clk rises.
// Notes: Codes 0..13 give a one-cycle event pulse, codes 16..26 toggle a level.
`timescale 1ns/100ps

module pif_periph_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [4:0] sel,
	output logic [13:0] evt_r,
	output logic [10:0] lvl_r
);
	// Event pulses last one cycle, because longer pulses would hide a missing sticky latch.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_r <= 14'h0000;
		end else begin
			evt_r <= (go && sel < 5'd16) ? (14'h0001 << sel[3:0]) : 14'h0000;
		end
	end

	// Levels hold until commanded again, like a buffer or comparator state.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_r <= 11'h000;
		end else if (go && sel >= 5'd16) begin
			lvl_r <= lvl_r ^ (11'h001 << (sel - 5'd16));
		end
	end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the peripheral interrupt flag block.
// Assumes: Zero-wait APB slave; flags settle a few cycles after their source.
// Notes: Drivers queue expectations; a monitor compares whenever a result appears.
`timescale 1ns/100ps
`include "pif_params.svh"

module tb_top;
	import pif_pkg::*;
	logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, probe_r = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [4:0] sel = 5'h00;
	logic [31:0] prdata;
	logic pready, pslverr, irq_high_r, irq_low_r;
	logic [13:0] evt;
	logic [10:0] lvl;
	logic [32:0] rd_q[$];
	logic [1:0] irq_q[$];
	int failures = 0, n_tests = 0, k;
	int bitpos[14] = '{0, 1, 1, 3, 7, 6, 3, 2, 0, 0, 1, 2, 4, 3};
	logic [11:0] fa[14] = '{0, 0, 4, 8, 0, 0, 0, 0, 4, 8, 8, 8, 4, 4};
	logic [7:0] rstv[10] = '{0, 0, 0, 0, 0, 0, 8'hff, 8'h5f, 8'h3f, 0};
	logic [7:0] rv;

	pif_periph_model i_pif_periph_model (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .sel(sel), .evt_r(evt), .lvl_r(lvl));

	pif_core i_pif_core (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_one_overflow(evt[0]), .timer_two_match(evt[1]), .timer_three_overflow(evt[2]),
		.timer_four_match(evt[3]), .parallel_port_event(evt[4]), .adc_done_event(evt[5]),
		.sync_serial_event(evt[6]), .capcomp_one_event(evt[7]), .capcomp_two_event(evt[8]),
		.capcomp_three_to_five_events(evt[11:9]), .nvm_write_done(evt[12]), .bus_collision(evt[13]),
		.comparator_change(lvl[0]), .low_voltage_trip(lvl[1]), .serial_one_rx_full(lvl[2]),
		.serial_one_tx_empty(lvl[3]), .serial_two_rx_full(lvl[4]), .serial_two_tx_empty(lvl[5]),
		.capcomp_one_pwm(lvl[6]), .capcomp_two_pwm(lvl[7]), .capcomp_three_to_five_pwm(lvl[10:8]),
		.irq_high_r(irq_high_r), .irq_low_r(irq_low_r));

	// ==========================================================
	// Clock, verdict and watchdog
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	task complete_run();
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// The span is over thirty times what the sequence needs, so only a real hang reaches it.
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		complete_run();
	end

	// ==========================================================
	// Drivers
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [11:0] a, input logic [7:0] e, input logic err);
		rd_q.push_back({err, 24'h00_0000, e});
		apb(1'b0, a, 8'h00);
	endtask

	task fire(input int s);
		@(posedge sys_clk);
		go <= 1'b1;
		sel <= 5'(s);
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	// Waits two cycles so the registered request has followed the last write.
	task probe(input logic [1:0] e);
		repeat (2) @(posedge sys_clk);
		irq_q.push_back(e);
		@(posedge sys_clk);
		probe_r <= 1'b1;
		@(posedge sys_clk);
		probe_r <= 1'b0;
	endtask

	// ==========================================================
	// Monitor and comparisons
	task cmp_rd(input logic [32:0] e);
		n_tests++;
		if ({pslverr, prdata} !== e) begin
			failures++;
			$display("BAD read expected %h seen %h", e, {pslverr, prdata});
		end
	endtask

	task cmp_irq(input logic [1:0] e);
		n_tests++;
		if ({irq_low_r, irq_high_r} !== e) begin
			failures++;
			$display("BAD irq expected %b seen %b", e, {irq_low_r, irq_high_r});
		end
	endtask

	// An empty queue yields unknowns, so an unexpected result always counts as a mismatch.
	always @(posedge sys_clk) begin
		if (psel && penable && !pwrite && pready === 1'b1)
			cmp_rd(rd_q.size() > 0 ? rd_q.pop_front() : 33'bx);
		if (probe_r)
			cmp_irq(irq_q.size() > 0 ? irq_q.pop_front() : 2'bx);
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'he777));
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (k = 0; k < 10; k++) rd(12'(4 * k), rstv[k], 1'b0);
		rd(12'h02C, 8'h00, 1'b1);
		for (k = 0; k < 3; k++) begin
			rv = 8'($urandom);
			apb(1'b1, `PIF_OFF_ENABLES_ONE + 12'(4 * k), rv);
			rd(`PIF_OFF_ENABLES_ONE + 12'(4 * k), rv & (k == 0 ? 8'hff : k == 1 ? 8'h5f : 8'h3f), 1'b0);
			apb(1'b1, `PIF_OFF_ENABLES_ONE + 12'(4 * k), 8'h00);
		end
		// Each event sets its own flag with every enable off; the flag holds until written zero.
		for (k = 0; k < 14; k++) begin
			fire(k);
			rd(fa[k], 8'h01 << bitpos[k], 1'b0);
			apb(1'b1, fa[k], 8'h00);
			rd(fa[k], 8'h00, 1'b0);
		end
		for (k = 0; k < 5; k++) begin
			fire(22 + k);
			fire(7 + k);
			rd(fa[7 + k], 8'h00, 1'b0);
			fire(22 + k);
		end
		// Comparator flags on both edges, low voltage on the falling supply only.
		for (k = 0; k < 2; k++) begin
			fire(16 + k);
			rd(`PIF_OFF_FLAGS_TWO, k ? 8'h04 : 8'h40, 1'b0);
			apb(1'b1, `PIF_OFF_FLAGS_TWO, 8'h00);
			fire(16 + k);
			rd(`PIF_OFF_FLAGS_TWO, k ? 8'h00 : 8'h40, 1'b0);
			apb(1'b1, `PIF_OFF_FLAGS_TWO, 8'h00);
		end
		// Buffer mirrors follow their level and ignore software writes.
		for (k = 0; k < 4; k++) begin
			fire(18 + k);
			rd(k < 2 ? `PIF_OFF_FLAGS_ONE : `PIF_OFF_FLAGS_THREE, k[0] ? 8'h10 : 8'h20, 1'b0);
			apb(1'b1, k < 2 ? `PIF_OFF_FLAGS_ONE : `PIF_OFF_FLAGS_THREE, 8'h00);
			rd(k < 2 ? `PIF_OFF_FLAGS_ONE : `PIF_OFF_FLAGS_THREE, k[0] ? 8'h10 : 8'h20, 1'b0);
			fire(18 + k);
			rd(k < 2 ? `PIF_OFF_FLAGS_ONE : `PIF_OFF_FLAGS_THREE, 8'h00, 1'b0);
		end
		// Request gating in single and priority modes.
		apb(1'b1, `PIF_OFF_ENABLES_ONE, 8'h81);
		fire(0);
		apb(1'b1, `PIF_OFF_CONTROL, 8'h01);
		probe(2'b01);
		apb(1'b1, `PIF_OFF_CONTROL, 8'h00);
		probe(2'b00);
		apb(1'b1, `PIF_OFF_FLAGS_ONE, 8'h80);
		apb(1'b1, `PIF_OFF_CONTROL, 8'h01);
		probe(2'b00);
		apb(1'b1, `PIF_OFF_CONTROL, 8'h05);
		probe(2'b01);
		apb(1'b1, `PIF_OFF_FLAGS_ONE, 8'h01);
		apb(1'b1, `PIF_OFF_CONTROL, 8'h02);
		probe(2'b01);
		apb(1'b1, `PIF_OFF_PRIORITY_ONE, 8'h00);
		probe(2'b00);
		apb(1'b1, `PIF_OFF_CONTROL, 8'h03);
		probe(2'b10);
		apb(1'b1, `PIF_OFF_CONTROL, 8'h01);
		probe(2'b01);
		rd(`PIF_OFF_STATUS, 8'h01, 1'b0);
		complete_run();
	end
endmodule
